// ### verilog/rbt_regs.vh
// Purpose: offsets, field positions, masks and reset values of the ramp burst/trigger bank
// Assumes: registers are 16 bits wide, one per aligned 32-bit word
// Notes:   byte address of a register is four times its index
`ifndef RBT_REGS_VH
`define RBT_REGS_VH

// register indices
`define RBT_IDX_RSVD_A        7'h5D
`define RBT_IDX_RSVD_B        7'h5E
`define RBT_IDX_RSVD_C        7'h5F
`define RBT_IDX_BURST_CFG     7'h60
`define RBT_IDX_TRIG_SEL      7'h61
`define RBT_IDX_SEG0_HIGH     7'h62
`define RBT_IDX_SEG0_LOW      7'h63
`define RBT_IDX_SEG0_DUR      7'h64
`define RBT_IDX_RAMP_CTRL     7'h70
`define RBT_IDX_RAMP_STAT     7'h71

// reset values
`define RBT_RST_VALUE         16'h0000

// writable bits per register, reserved bits kept at zero
`define RBT_MASK_BURST_CFG    16'hFFFC
`define RBT_MASK_TRIG_SEL     16'h87FB
`define RBT_MASK_SEG0_HIGH    16'hFFFD
`define RBT_MASK_FULL         16'hFFFF
`define RBT_MASK_RAMP_CTRL    16'h0003

// burst_config fields
`define RBT_BURST_EN_BIT      15
`define RBT_BURST_CNT_MSB     14
`define RBT_BURST_CNT_LSB     2

// trigger_select fields
`define RBT_ACCUM_CLR_BIT     15
`define RBT_TRIG_TWO_MSB      10
`define RBT_TRIG_TWO_LSB      7
`define RBT_TRIG_ONE_MSB      6
`define RBT_TRIG_ONE_LSB      3
`define RBT_ADV_SEL_MSB       1
`define RBT_ADV_SEL_LSB       0

// seg0_step_high_cfg fields
`define RBT_STEP_HIGH_MSB     15
`define RBT_STEP_HIGH_LSB     2
`define RBT_STRETCH_BIT       0

// ramp_ctrl fields
`define RBT_CTRL_EN_BIT       0
`define RBT_CTRL_MANUAL_BIT   1
`define RBT_CTRL_SRST_BIT     2

// trigger source codes
`define RBT_TSRC_OFF          4'h0
`define RBT_TSRC_CLK_RISE     4'h1
`define RBT_TSRC_DIR_RISE     4'h2
`define RBT_TSRC_ALWAYS       4'h4
`define RBT_TSRC_CLK_FALL     4'h9
`define RBT_TSRC_DIR_FALL     4'hA

// burst advance codes
`define RBT_ADV_TRANSITION    2'h0
`define RBT_ADV_TRIG_ONE      2'h1
`define RBT_ADV_TRIG_TWO      2'h2

// ref_clk cycles per phase detector cycle
`define RBT_PD_DIV            8'h01

`endif

// ### verilog/rbt_trig.v
// Purpose: one trigger source, decoded from a 4-bit selector
// Assumes: pins synchronous to ref_clk, pd_tick one ref_clk cycle wide
// Notes:   event is a one-cycle pulse aligned to a phase detector tick
`timescale 1ns/1ps
`include "rbt_regs.vh"

module rbt_trig
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // phase detector rate
    input  wire       pd_tick,
    // configuration
    input  wire [3:0] source_sel,
    // pins
    input  wire       ramp_clock_pin,
    input  wire       ramp_direction_pin,
    // result
    output reg        trig_event
);

reg  clk_q;
reg  dir_q;
reg  next_event;

always @*
begin
    case (source_sel)
        `RBT_TSRC_CLK_RISE: next_event = ramp_clock_pin & ~clk_q;
        `RBT_TSRC_DIR_RISE: next_event = ramp_direction_pin & ~dir_q;
        `RBT_TSRC_ALWAYS:   next_event = 1'b1;
        `RBT_TSRC_CLK_FALL: next_event = ~ramp_clock_pin & clk_q;
        `RBT_TSRC_DIR_FALL: next_event = ~ramp_direction_pin & dir_q;
        default:            next_event = 1'b0;
    endcase
end

// pins sampled once per phase detector cycle
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        clk_q      <= 1'b0;
        dir_q      <= 1'b0;
        trig_event <= 1'b0;
    end
    else
    begin
        trig_event <= 1'b0;
        if (pd_tick)
        begin
            clk_q      <= ramp_clock_pin;
            dir_q      <= ramp_direction_pin;
            trig_event <= next_event;
        end
    end
end

endmodule // rbt_trig

// ### verilog/rbt_top.v
// Purpose: ramp burst, trigger and segment-0 configuration bank with its ramp engine
// Assumes: Avalon-MM slave, 32-bit data, one wait state per access
// Notes:   registers 16 bits wide in the low half of each word
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rbt_regs.vh"

module rbt_top
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // avalon-mm slave
    input  wire [8:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // ramp pins
    input  wire        ramp_clock_pin,
    input  wire        ramp_direction_pin,
    // ramp engine outputs
    output reg  [31:0] frac_accum,
    output reg         ramp_active,
    output reg         ramp_start,
    output reg         burst_done
);

localparam ST_IDLE = 2'b00;
localparam ST_RAMP = 2'b01;
localparam ST_WAIT = 2'b10;
localparam ST_DONE = 2'b11;

////////////////////////////////////////////////////////////////////////////////
// register storage

reg  [15:0] burst_config;
reg  [15:0] trigger_select;
reg  [15:0] seg0_step_high_cfg;
reg  [15:0] seg0_step_low;
reg  [15:0] seg0_duration;
reg  [15:0] ramp_ctrl;

reg  [1:0]  state;
reg  [12:0] ramps_done;
reg  [15:0] len_count;
reg  [7:0]  pd_count;
reg         pd_tick;
reg         half_q;
reg         en_q;
reg  [31:0] next_readdata;

wire [6:0]  reg_index   = avs_address[8:2];
wire        aligned     = (avs_address[1:0] == 2'b00);
wire        req         = avs_read | avs_write;
wire        wr_commit   = avs_write & ~avs_waitrequest & aligned;
wire [15:0] lane_mask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
wire        soft_reset  = wr_commit & (reg_index == `RBT_IDX_RAMP_CTRL)
                          & avs_byteenable[0] & avs_writedata[`RBT_CTRL_SRST_BIT];

// field views
wire        burst_en     = burst_config[`RBT_BURST_EN_BIT];
wire [12:0] burst_count  = burst_config[`RBT_BURST_CNT_MSB:`RBT_BURST_CNT_LSB];
wire        accum_clear  = trigger_select[`RBT_ACCUM_CLR_BIT];
wire [3:0]  trig_two_sel = trigger_select[`RBT_TRIG_TWO_MSB:`RBT_TRIG_TWO_LSB];
wire [3:0]  trig_one_sel = trigger_select[`RBT_TRIG_ONE_MSB:`RBT_TRIG_ONE_LSB];
wire [1:0]  advance_sel  = trigger_select[`RBT_ADV_SEL_MSB:`RBT_ADV_SEL_LSB];
wire        clock_stretch = seg0_step_high_cfg[`RBT_STRETCH_BIT];
wire [29:0] seg0_step_value = {seg0_step_high_cfg[`RBT_STEP_HIGH_MSB:`RBT_STEP_HIGH_LSB],
                               seg0_step_low};
wire        ramp_enable  = ramp_ctrl[`RBT_CTRL_EN_BIT];
wire        manual_mode  = ramp_ctrl[`RBT_CTRL_MANUAL_BIT];

// merge of written lanes into a register under its writable mask
function [15:0] merge;
    input [15:0] old_val;
    input [15:0] wdata;
    input [15:0] lanes;
    input [15:0] wmask;
    reg   [15:0] sel;
    begin
        sel   = lanes & wmask;
        merge = (old_val & ~sel) | (wdata & sel);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus slave

always @*
begin
    next_readdata = 32'h00000000;
    if (aligned)
    begin
        case (reg_index)
            `RBT_IDX_BURST_CFG: next_readdata = {16'h0000, burst_config};
            `RBT_IDX_TRIG_SEL:  next_readdata = {16'h0000, trigger_select};
            `RBT_IDX_SEG0_HIGH: next_readdata = {16'h0000, seg0_step_high_cfg};
            `RBT_IDX_SEG0_LOW:  next_readdata = {16'h0000, seg0_step_low};
            `RBT_IDX_SEG0_DUR:  next_readdata = {16'h0000, seg0_duration};
            `RBT_IDX_RAMP_CTRL: next_readdata = {16'h0000, ramp_ctrl};
            `RBT_IDX_RAMP_STAT: next_readdata = {16'h0000, ramps_done, state == ST_WAIT,
                                                 burst_done, ramp_active};
            default:            next_readdata = 32'h00000000;
        endcase
    end
end

// one wait state: data latched on first edge, write commits on the released edge
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h00000000;
    end
    else
    begin
        if (req && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? next_readdata : 32'h00000000;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end
end

// reserved registers hold no storage and read as zero
always @(posedge ref_clk)
begin
    if (!rst_b || soft_reset)
    begin
        burst_config       <= `RBT_RST_VALUE;
        trigger_select     <= `RBT_RST_VALUE;
        seg0_step_high_cfg <= `RBT_RST_VALUE;
        seg0_step_low      <= `RBT_RST_VALUE;
        seg0_duration      <= `RBT_RST_VALUE;
        ramp_ctrl          <= `RBT_RST_VALUE;
    end
    else if (wr_commit)
    begin
        case (reg_index)
            `RBT_IDX_BURST_CFG:
                burst_config <= merge(burst_config, avs_writedata[15:0], lane_mask,
                                      `RBT_MASK_BURST_CFG);
            `RBT_IDX_TRIG_SEL:
                trigger_select <= merge(trigger_select, avs_writedata[15:0], lane_mask,
                                        `RBT_MASK_TRIG_SEL);
            `RBT_IDX_SEG0_HIGH:
                seg0_step_high_cfg <= merge(seg0_step_high_cfg, avs_writedata[15:0],
                                            lane_mask, `RBT_MASK_SEG0_HIGH);
            `RBT_IDX_SEG0_LOW:
                seg0_step_low <= merge(seg0_step_low, avs_writedata[15:0], lane_mask,
                                       `RBT_MASK_FULL);
            `RBT_IDX_SEG0_DUR:
                seg0_duration <= merge(seg0_duration, avs_writedata[15:0], lane_mask,
                                       `RBT_MASK_FULL);
            `RBT_IDX_RAMP_CTRL:
                ramp_ctrl <= merge(ramp_ctrl, avs_writedata[15:0], lane_mask,
                                   `RBT_MASK_RAMP_CTRL);
            default:
                ramp_ctrl <= ramp_ctrl;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// phase detector tick and ramp clock

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        pd_count <= 8'h00;
        pd_tick  <= 1'b0;
        half_q   <= 1'b0;
    end
    else
    begin
        if (pd_count >= `RBT_PD_DIV - 8'h01)
        begin
            pd_count <= 8'h00;
            pd_tick  <= 1'b1;
        end
        else
        begin
            pd_count <= pd_count + 8'h01;
            pd_tick  <= 1'b0;
        end
        if (pd_tick)
            half_q <= ~half_q;
    end
end

wire ramp_tick = pd_tick & (~clock_stretch | half_q);

////////////////////////////////////////////////////////////////////////////////
// triggers

wire trig_one_event;
wire trig_two_event;

rbt_trig u_trig_one
(
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .pd_tick            (pd_tick),
    .source_sel         (trig_one_sel),
    .ramp_clock_pin     (ramp_clock_pin),
    .ramp_direction_pin (ramp_direction_pin),
    .trig_event         (trig_one_event)
);

rbt_trig u_trig_two
(
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .pd_tick            (pd_tick),
    .source_sel         (trig_two_sel),
    .ramp_clock_pin     (ramp_clock_pin),
    .ramp_direction_pin (ramp_direction_pin),
    .trig_event         (trig_two_event)
);

reg advance_go;

always @*
begin
    case (advance_sel)
        `RBT_ADV_TRANSITION: advance_go = 1'b1;
        `RBT_ADV_TRIG_ONE:   advance_go = trig_one_event;
        `RBT_ADV_TRIG_TWO:   advance_go = trig_two_event;
        default:             advance_go = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// ramp engine

wire        en_rise    = ramp_enable & ~en_q;
wire        last_clock = (len_count + 16'h0001 >= seg0_duration);
wire [12:0] done_inc   = ramps_done + 13'h0001;
wire [31:0] step_ext   = {{2{seg0_step_value[29]}}, seg0_step_value};
wire        clear_ok   = accum_clear & ~manual_mode;

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        state       <= ST_IDLE;
        en_q        <= 1'b0;
        ramps_done  <= 13'h0000;
        len_count   <= 16'h0000;
        frac_accum  <= 32'h00000000;
        ramp_active <= 1'b0;
        ramp_start  <= 1'b0;
        burst_done  <= 1'b0;
    end
    else
    begin
        en_q       <= ramp_enable;
        ramp_start <= 1'b0;
        if (!ramp_enable)
        begin
            state       <= ST_IDLE;
            ramp_active <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (en_rise)
                    begin
                        ramps_done <= 13'h0000;
                        burst_done <= 1'b0;
                        len_count  <= 16'h0000;
                        if (burst_en && burst_count == 13'h0000)
                        begin
                            state      <= ST_DONE;
                            burst_done <= 1'b1;
                        end
                        else
                        begin
                            state       <= ST_RAMP;
                            ramp_active <= 1'b1;
                            ramp_start  <= 1'b1;
                            if (clear_ok)
                                frac_accum <= 32'h00000000;
                        end
                    end
                end
                ST_RAMP:
                begin
                    if (ramp_tick)
                    begin
                        frac_accum <= frac_accum + step_ext;
                        len_count  <= len_count + 16'h0001;
                        if (last_clock)
                        begin
                            len_count <= 16'h0000;
                            if (burst_en)
                            begin
                                ramps_done <= done_inc;
                                if (done_inc == burst_count)
                                begin
                                    state       <= ST_DONE;
                                    ramp_active <= 1'b0;
                                    burst_done  <= 1'b1;
                                end
                                else
                                begin
                                    state <= ST_WAIT;
                                end
                            end
                            else
                            begin
                                ramp_start <= 1'b1;
                                if (clear_ok)
                                    frac_accum <= 32'h00000000;
                            end
                        end
                    end
                end
                ST_WAIT:
                begin
                    if (advance_go)
                    begin
                        state      <= ST_RAMP;
                        ramp_start <= 1'b1;
                        if (clear_ok)
                            frac_accum <= 32'h00000000;
                    end
                end
                ST_DONE:
                begin
                    ramp_active <= 1'b0;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule // rbt_top

// ### sim/rbt_checker.sv
// Purpose: port checker for the ramp burst bank
// Assumes: one clock, rst_b synchronous active low
// Notes:   bound to every rbt_top instance
`timescale 1ns/1ps
module rbt_checker
(
    // clock and reset
    input wire        ref_clk,
    input wire        rst_b,
    // bus
    input wire [8:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // engine
    input wire [31:0] frac_accum,
    input wire        ramp_active,
    input wire        ramp_start,
    input wire        burst_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire req    = avs_read | avs_write;
    wire rd_end = avs_read & ~avs_waitrequest;
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state not one cycle");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(req))
        else $error("answer without request");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_read_upper: assert property (rd_end |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_rsvd_zero: assert property (rd_end
        && avs_address[8:2] inside {7'h5D, 7'h5E, 7'h5F} |-> avs_readdata == 32'h0)
        else $error("reserved register not zero");
    a_unaligned_zero: assert property (rd_end && avs_address[1:0] != 2'h0
        |-> avs_readdata == 32'h0)
        else $error("unaligned read not zero");
    a_start_active: assert property (ramp_start |-> ramp_active)
        else $error("ramp start while idle");
    a_done_quiet: assert property (burst_done |-> !ramp_start && !ramp_active)
        else $error("ramp after burst end");
    a_accum_frozen: assert property (!ramp_active && !$past(ramp_active)
        |-> $stable(frac_accum))
        else $error("accumulator moved while idle");
    cover property (ramp_start);
    cover property ($rose(burst_done));
    cover property (rd_end);
endmodule // rbt_checker

bind rbt_top rbt_checker rbt_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .frac_accum(frac_accum), .ramp_active(ramp_active), .ramp_start(ramp_start),
    .burst_done(burst_done));

// ### sim/rbt_host_pins.sv
// Purpose: far-side logic driving the two ramp pins
// Assumes: bench asks for pin levels through want
// Notes:   want[0] clock pin, want[1] direction pin
`timescale 1ns/1ps
module rbt_host_pins
(
    // clock and reset
    input wire       ref_clk,
    input wire       rst_b,
    // request
    input wire [1:0] want,
    // pins
    output reg       ramp_clock_pin,
    output reg       ramp_direction_pin
);
    // levels move on ref_clk only, so each holds a full pd tick
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ramp_clock_pin     <= 1'b0;
            ramp_direction_pin <= 1'b0;
        end
        else
        begin
            ramp_clock_pin     <= want[0];
            ramp_direction_pin <= want[1];
        end
    end
endmodule // rbt_host_pins

// ### sim/test_ramp_burst_trigger_config.sv
// Purpose: self-checking bench for the ramp burst bank
// Assumes: one wait state bus, pd tick every ref_clk
// Notes:   random register data and ramp shapes, fixed seed
`timescale 1ns/1ps
`include "rbt_regs.vh"
module test_ramp_burst_trigger_config;
    reg         ref_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [8:0]  avs_address = 9'h000;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [1:0]  want = 2'h0;
    wire [31:0] avs_readdata;
    wire [31:0] frac_accum;
    wire        avs_waitrequest, ramp_clock_pin, ramp_direction_pin;
    wire        ramp_active, ramp_start, burst_done;
    integer     n_errors = 0, checks_done = 0, starts = 0, act = 0, i, k, t;
    reg  [31:0] rd;
    reg  [15:0] wv [0:8];
    localparam [62:0] IDXS = {`RBT_IDX_RSVD_A, `RBT_IDX_RSVD_B, `RBT_IDX_RSVD_C,
        `RBT_IDX_BURST_CFG, `RBT_IDX_TRIG_SEL, `RBT_IDX_SEG0_HIGH, `RBT_IDX_SEG0_LOW,
        `RBT_IDX_SEG0_DUR, 7'h50};
    localparam [143:0] MSKS = {48'h0, `RBT_MASK_BURST_CFG, `RBT_MASK_TRIG_SEL,
        `RBT_MASK_SEG0_HIGH, `RBT_MASK_FULL, `RBT_MASK_FULL, 16'h0000};
    localparam [27:0] CODES = {`RBT_TSRC_OFF, `RBT_TSRC_CLK_RISE, `RBT_TSRC_DIR_RISE, 4'h3,
        `RBT_TSRC_ALWAYS, `RBT_TSRC_CLK_FALL, `RBT_TSRC_DIR_FALL};

    rbt_top rbt_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ramp_clock_pin(ramp_clock_pin), .ramp_direction_pin(ramp_direction_pin),
        .frac_accum(frac_accum), .ramp_active(ramp_active), .ramp_start(ramp_start),
        .burst_done(burst_done));
    rbt_host_pins rbt_host_pins_inst (.ref_clk(ref_clk), .rst_b(rst_b), .want(want),
        .ramp_clock_pin(ramp_clock_pin), .ramp_direction_pin(ramp_direction_pin));

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        starts <= starts + (ramp_start === 1'b1);
        act    <= act + (ramp_active === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    function [8:0] ad(input [6:0] idx);
        ad = {idx, 2'b00};
    endfunction
    function [31:0] exp_acc(input [29:0] s, input [15:0] d, input [12:0] m);
        exp_acc = {{2{s[29]}}, s} * ((d == 16'h0) ? 16'h1 : d) * m;
    endfunction
    // one access, held until waitrequest is sampled low
    task bus(input r, input [8:0] a, input [15:0] wd);
        begin
            @(posedge ref_clk);
            avs_read <= r;
            avs_write <= !r;
            avs_address <= a;
            avs_writedata <= {16'h0000, wd};
            @(posedge ref_clk);
            // only the watchdog ends a wait that never answers
            while (avs_waitrequest !== 1'b0)
                @(posedge ref_clk);
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task rdc(input [8:0] a, input [15:0] exp);
        begin
            bus(1'b1, a, 16'h0000);
            check(rd, {16'h0000, exp});
        end
    endtask
    task run_ramp(input [12:0] n, input [15:0] d, input st, input clr, input [29:0] s,
        input man, input [31:0] b);
        integer s0, a0, lo;
        reg [31:0] e;
        begin
            bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0000);
            bus(1'b0, ad(`RBT_IDX_SEG0_HIGH), {s[29:16], 1'b0, st});
            bus(1'b0, ad(`RBT_IDX_SEG0_LOW), s[15:0]);
            bus(1'b0, ad(`RBT_IDX_SEG0_DUR), d);
            bus(1'b0, ad(`RBT_IDX_BURST_CFG), {1'b1, n, 2'b00});
            bus(1'b0, ad(`RBT_IDX_TRIG_SEL), {clr, 15'h0000});
            s0 = starts;
            a0 = act;
            bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), {14'h0000, man, 1'b1});
            repeat (3) @(posedge ref_clk);
            while (burst_done !== 1'b1)
                @(posedge ref_clk);
            repeat (10) @(posedge ref_clk);
            e = b + exp_acc(s, d, (clr && !man) ? 13'h1 : n);
            // half-rate phase may already be high at the first ramp cycle
            lo = st ? 2 * n * ((d == 16'h0) ? 1 : d) - 1 : n * d;
            check(starts - s0, n);
            check(frac_accum, e);
            check((act - a0) >= lo, 1);
            rdc(ad(`RBT_IDX_RAMP_STAT), {n, 1'b0, 1'b1, 1'b0});
        end
    endtask
    task trig(input integer t, input [3:0] c);
        integer s0;
        reg p, dead;
        begin
            p = c[1];
            dead = (c == 4'h0 || c == 4'h3);
            want <= 2'h0;
            bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0000);
            bus(1'b0, ad(`RBT_IDX_SEG0_DUR), 16'h0001);
            bus(1'b0, ad(`RBT_IDX_BURST_CFG), {1'b1, 13'h0002, 2'b00});
            bus(1'b0, ad(`RBT_IDX_TRIG_SEL), (t == 1) ? {9'h000, c, 1'b0, `RBT_ADV_TRIG_ONE}
                : {5'h00, c, 5'h00, `RBT_ADV_TRIG_TWO});
            s0 = starts;
            bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0001);
            repeat (12) @(posedge ref_clk);
            check(starts - s0, (c == 4'h4) ? 2 : 1);
            want <= p ? 2'b01 : 2'b10;
            repeat (6) @(posedge ref_clk);
            want <= 2'b00;
            repeat (6) @(posedge ref_clk);
            check(starts - s0, (c == 4'h4) ? 2 : 1);
            want <= p ? 2'b10 : 2'b01;
            repeat (6) @(posedge ref_clk);
            check(starts - s0, (c == 4'h4 || c == 4'h1 || c == 4'h2) ? 2 : 1);
            want <= 2'b00;
            repeat (6) @(posedge ref_clk);
            check(starts - s0, dead ? 1 : 2);
            check(burst_done, !dead);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h9C57FF6E));
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 9; i = i + 1)
            rdc(ad(IDXS[i*7 +: 7]), 16'h0000);
        for (k = 0; k < 3; k = k + 1)
        begin
            for (i = 0; i < 9; i = i + 1)
            begin
                wv[i] = (i == 0) ? $urandom : $urandom & MSKS[i*16 +: 16];
                bus(1'b0, ad(IDXS[i*7 +: 7]), wv[i]);
            end
            for (i = 0; i < 9; i = i + 1)
                rdc(ad(IDXS[i*7 +: 7]), wv[i] & MSKS[i*16 +: 16]);
        end
        bus(1'b0, {`RBT_IDX_BURST_CFG, 2'b10}, 16'h5554);
        rdc({`RBT_IDX_BURST_CFG, 2'b01}, 16'h0000);
        rdc(ad(`RBT_IDX_BURST_CFG), wv[5] & `RBT_MASK_BURST_CFG);
        run_ramp(13'h0, 16'h2, 1'b0, 1'b0, 30'h3FFFFFF5, 1'b0, 32'h0);
        run_ramp(13'h3, 16'h2, 1'b0, 1'b0, 30'h3FFFFFF5, 1'b0, 32'h0);
        // manual mode keeps the sum of the previous burst
        run_ramp(13'h2, 16'h2, 1'b0, 1'b1, 30'h3FFFFFF5, 1'b1,
                 exp_acc(30'h3FFFFFF5, 16'h2, 13'h3));
        // burst mode off: ramps repeat every two cycles
        bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0000);
        bus(1'b0, ad(`RBT_IDX_BURST_CFG), 16'h0000);
        k = starts;
        bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0001);
        repeat (20) @(posedge ref_clk);
        check(starts - k, 9);
        // soft reset clears every writable field and stops the engine
        bus(1'b0, ad(`RBT_IDX_RAMP_CTRL), 16'h0004);
        rdc(ad(`RBT_IDX_TRIG_SEL), 16'h0000);
        rdc(ad(`RBT_IDX_RAMP_CTRL), 16'h0000);
        rdc(ad(`RBT_IDX_RAMP_STAT), 16'h0000);
        rdc(ad(`RBT_IDX_RSVD_B), 16'h0000);
        for (k = 0; k < 5; k = k + 1)
            run_ramp($urandom_range(1, 4), $urandom_range(0, 5), $urandom, 1'b1, $urandom,
                     1'b0, 32'h0);
        for (t = 1; t <= 2; t = t + 1)
            for (i = 0; i < 7; i = i + 1)
                trig(t, CODES[i*4 +: 4]);
        report_and_stop;
    end
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_errors = n_errors + 1;
        report_and_stop;
    end
endmodule // test_ramp_burst_trigger_config
